// *** pkg/sfpi_pkg.sv ***
// shared constants, enums and carriers for the serial flash pin interface
package sfpi_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 125;
	localparam int RESET_MIN_NS = 1000;
	// least time, rounded up to whole clock cycles
	localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// widths and field layout
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int LANE_N = 4;
	localparam int CNT_W = 3;
	localparam int PIN_W = 7;
	localparam logic [LANE_N-1:0] OE_ALL_OFF = 4'hF;
	localparam logic [LANE_N-1:0] OE_SINGLE = 4'hD;
	localparam logic [LANE_N-1:0] OE_DUAL = 4'hC;
	localparam logic [LANE_N-1:0] OE_QUAD = 4'h0;
	// pin idle levels: select high, reset high, clock low, lanes high
	localparam logic [PIN_W-1:0] PIN_IDLE = 7'h6F;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SFPI_SINGLE, SFPI_DUAL, SFPI_QUAD} sfpi_mode_e;
	typedef enum logic [1:0] {ST_WAIT, ST_ACTIVE, ST_PAUSED} sfpi_state_e;

	typedef struct packed {
		logic cs_n;
		logic hw_rst_n;
		logic sclk;
		logic [LANE_N-1:0] lane;
	} sfpi_pins_s;

	typedef struct packed {
		logic valid;
		logic first;
		logic [BYTE_W-1:0] data;
	} sfpi_rx_s;

endpackage

// *** sim/sfpi_core_monitor.sv ***
// checker bound to the pin interface core
`timescale 1ns/1ps
module sfpi_core_monitor
	import sfpi_pkg::*;
#(
	parameter int RESET_MIN_CYCLES = 4
) (
	input wire logic clk, // clock
	input wire logic reset, // reset
	input wire logic pin_cs_n, // select
	input wire logic pin_hw_rst_n, // reset pin
	input wire logic [3:0] data_lane_oe_n, // enables
	input wire logic quad_enable_bit, // quad on
	input wire sfpi_pkg::sfpi_mode_e xfer_mode, // mode
	input wire logic tx_take, // byte taken
	input wire sfpi_pkg::sfpi_rx_s rx, // byte in
	input wire logic selected, // frame
	input wire logic paused, // pause
	input wire logic quad_refused, // refusal
	input wire logic hw_abort // abort
);
	logic [7:0] low_q;

	// cycles the reset pin has been low
	always_ff @(posedge clk)
	begin
		if (reset || pin_hw_rst_n)
			low_q <= 8'h00;
		else if (low_q != 8'hFF)
			low_q <= low_q + 8'h01;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	chk_desel_float: assert property (pin_cs_n [*5] |->
		data_lane_oe_n == 4'hF && !selected && !quad_refused) else $error("live when idle");
	chk_rx_framed: assert property (rx.valid |-> $past(selected) && !$past(rx.valid))
		else $error("rx outside frame");
	chk_single_tx: assert property (tx_take && xfer_mode == SFPI_SINGLE |->
		data_lane_oe_n == 4'hD) else $error("bad single drive");
	chk_single_lanes: assert property ((xfer_mode == SFPI_SINGLE) [*4] |->
		data_lane_oe_n[0] && data_lane_oe_n[3:2] == 2'h3) else $error("lane misuse");
	chk_quad_gate: assert property ((xfer_mode == SFPI_QUAD && !quad_enable_bit) [*4] |->
		data_lane_oe_n == 4'hF) else $error("quad not gated");
	chk_pause_float: assert property (paused |-> data_lane_oe_n == 4'hF)
		else $error("drive while paused");
	chk_quad_nopause: assert property (quad_enable_bit [*4] |-> !paused)
		else $error("pause in quad");
	chk_abort_time: assert property (hw_abort |-> low_q >= RESET_MIN_CYCLES ##1 !selected)
		else $error("early abort");
	cover property (rx.valid && rx.first);
	cover property (tx_take);
	cover property (hw_abort);
endmodule

// *** sim/sfpi_host.sv ***
// spi host model: select, clock and lanes
`timescale 1ns/1ps
module sfpi_host (
	input wire logic clk, // bench clock
	input wire logic [3:0] data_lane_in, // resolved lanes
	output logic pin_cs_n, // select
	output logic pin_sclk, // link clock
	output logic [3:0] drv, // lane values
	output logic [3:0] en // lane enables
);
	logic [7:0] q;

	// idle levels: deselected, clock low, lanes released
	initial
	begin
		pin_cs_n = 1'b1;
		pin_sclk = 1'b0;
		drv = 4'hF;
		en = 4'h0;
	end

	// half period of the 160 ns link clock
	task automatic half();
		repeat (10) @(posedge clk);
	endtask

	// frame edge, clock left where it is
	task automatic sel(input logic v);
		pin_cs_n <= v;
		half();
	endtask

	task automatic hold(input logic v);
		en[3] <= !v;
		drv[3] <= v;
	endtask

	// set after fall, sample at rise
	task automatic xfer(input logic [7:0] d, input int n, input bit rd, input int e);
		logic [7:0] s;
		logic [3:0] m;
		s = d;
		q = 8'h00;
		m = 4'((1 << n) - 1);
		en <= rd ? en & ~m : en | m;
		for (int i = 0; i < e; i++)
		begin
			pin_sclk <= 1'b0;
			drv <= (drv & ~m) | (4'(s >> (8 - n)) & m);
			s = s << n;
			half();
			pin_sclk <= 1'b1;
			q = (q << n) | 8'((n == 1 ? data_lane_in >> 1 : data_lane_in) & m);
			half();
		end
	endtask
endmodule

// *** sim/tb_top.sv ***
// self-checking bench for the pin interface core
`timescale 1ns/1ps
`define CHK(n, e, g) \
	begin \
		n_checks++; \
		if ((g) !== (e)) \
		begin \
			num_errors++; \
			$display("unexpected %s: %0h expected, %0h seen", n, e, g); \
		end \
	end

module tb_top;
	import sfpi_pkg::*;
	logic clk = 1'b0;
	logic reset;
	logic pin_hw_rst_n;
	logic quad_enable_bit;
	logic xfer_dir_out;
	logic [7:0] tx_data;
	sfpi_mode_e xfer_mode;
	logic pin_cs_n, pin_sclk, tx_take, selected, paused, quad_refused, hw_abort;
	logic [3:0] data_lane_in, data_lane_out, data_lane_oe_n, drv, en;
	sfpi_rx_s rx, rx_q;
	int num_errors = 0;
	int n_checks = 0;
	int rx_n = 0;
	int take_n = 0;
	int abort_n = 0;

	always #4 clk = ~clk;

	// released lanes pull high
	assign data_lane_in = ~data_lane_oe_n & data_lane_out | data_lane_oe_n & (drv | ~en);

	sfpi_host h (
		.clk(clk),
		.data_lane_in(data_lane_in),
		.pin_cs_n(pin_cs_n),
		.pin_sclk(pin_sclk),
		.drv(drv),
		.en(en)
	);
	sfpi_core #(.RESET_MIN_CYCLES(4)) dut (
		.clk(clk),
		.reset(reset),
		.pin_cs_n(pin_cs_n),
		.pin_sclk(pin_sclk),
		.pin_hw_rst_n(pin_hw_rst_n),
		.data_lane_in(data_lane_in),
		.data_lane_out(data_lane_out),
		.data_lane_oe_n(data_lane_oe_n),
		.quad_enable_bit(quad_enable_bit),
		.xfer_mode(xfer_mode),
		.xfer_dir_out(xfer_dir_out),
		.tx_data(tx_data),
		.tx_take(tx_take),
		.rx(rx),
		.selected(selected),
		.paused(paused),
		.quad_refused(quad_refused),
		.hw_abort(hw_abort)
	);

	// tallies of output pulses
	always @(posedge clk)
	begin
		if (rx.valid === 1'b1)
		begin
			rx_n <= rx_n + 1;
			rx_q <= rx;
		end
		if (tx_take === 1'b1)
			take_n <= take_n + 1;
		if (hw_abort === 1'b1)
			abort_n <= abort_n + 1;
	end

	// short pulse ignored, long one aborts
	task automatic t_abort();
		h.sel(1'b0);
		pin_hw_rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		pin_hw_rst_n <= 1'b1;
		h.half();
		`CHK("short", 0, abort_n)
		pin_hw_rst_n <= 1'b0;
		repeat (8) @(posedge clk);
		pin_hw_rst_n <= 1'b1;
		h.half();
		`CHK("abort", 1, abort_n)
		`CHK("closed", 1'b0, selected)
		h.xfer(8'hA5, 1, 0, 8);
		`CHK("ignored", 0, rx_n)
		h.sel(1'b1);
	endtask

	// single bytes, partial byte dropped
	task automatic t_single();
		h.sel(1'b0);
		h.xfer(8'hA5, 1, 0, 8);
		`CHK("rx", 10'h3A5, rx_q)
		h.xfer(8'h3C, 1, 0, 8);
		`CHK("rx2", 10'h23C, rx_q)
		h.xfer(8'hFF, 1, 0, 3);
		h.sel(1'b1);
		h.sel(1'b0);
		h.xfer(8'h81, 1, 0, 8);
		`CHK("realign", 10'h381, rx_q)
		h.sel(1'b1);
	endtask

	// single read on lane one
	task automatic t_tx();
		int n;
		tx_data <= 8'hC3;
		h.sel(1'b0);
		h.xfer(8'h0B, 1, 0, 8);
		n = take_n;
		xfer_dir_out <= 1'b1;
		h.xfer(8'h00, 1, 1, 8);
		`CHK("read", 8'hC3, h.q)
		`CHK("takes", n + 1, take_n)
		`CHK("drive", 4'hD, data_lane_oe_n)
		h.sel(1'b1);
		xfer_dir_out <= 1'b0;
		`CHK("float", 4'hF, data_lane_oe_n)
	endtask

	// dual and quad, both ways
	task automatic t_multi();
		logic [7:0] w;
		int n;
		quad_enable_bit <= 1'b1;
		for (int k = 0; k < 2; k++)
		begin
			n = 2 << k;
			w = k ? 8'h96 : 8'h5A;
			xfer_mode <= k ? SFPI_QUAD : SFPI_DUAL;
			tx_data <= ~w;
			h.sel(1'b0);
			h.xfer(w, n, 0, 8 / n);
			`CHK("mrx", {2'b11, w}, rx_q)
			xfer_dir_out <= 1'b1;
			h.xfer(8'h00, n, 1, 8 / n);
			`CHK("mread", ~w, h.q)
			h.sel(1'b1);
			xfer_dir_out <= 1'b0;
		end
	endtask

	// pause only without quad enable
	task automatic t_pause();
		xfer_mode <= SFPI_SINGLE;
		h.sel(1'b0);
		h.hold(1'b0);
		h.half();
		`CHK("nopause", 1'b0, paused)
		h.hold(1'b1);
		h.sel(1'b1);
		quad_enable_bit <= 1'b0;
		h.sel(1'b0);
		h.hold(1'b0);
		h.half();
		`CHK("paused", 1'b1, paused)
		h.xfer(8'hFF, 1, 0, 8);
		h.hold(1'b1);
		h.half();
		h.xfer(8'h69, 1, 0, 8);
		`CHK("resume", 10'h369, rx_q)
		h.sel(1'b1);
	endtask

	// quad refused without enable
	task automatic t_refuse();
		int n;
		n = rx_n;
		xfer_mode <= SFPI_QUAD;
		h.sel(1'b0);
		h.xfer(8'hEE, 4, 0, 2);
		`CHK("refused", 1'b1, quad_refused)
		`CHK("norx", n, rx_n)
		h.sel(1'b1);
		`CHK("cleared", 1'b0, quad_refused)
		`CHK("noabort", 1, abort_n)
	endtask

	// counts and verdict
	task automatic results();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// main sequence
	initial
	begin
		reset <= 1'b1;
		pin_hw_rst_n <= 1'b1;
		quad_enable_bit <= 1'b0;
		xfer_dir_out <= 1'b0;
		tx_data <= 8'h00;
		xfer_mode <= SFPI_SINGLE;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		t_abort();
		t_single();
		t_tx();
		t_multi();
		t_pause();
		t_refuse();
		results();
	end

	// hang limit
	initial
	begin
		repeat (100000) @(posedge clk);
		num_errors++;
		results();
	end
endmodule

bind sfpi_core sfpi_core_monitor #(.RESET_MIN_CYCLES(RESET_MIN_CYCLES)) mon (
	.clk(clk),
	.reset(reset),
	.pin_cs_n(pin_cs_n),
	.pin_hw_rst_n(pin_hw_rst_n),
	.data_lane_oe_n(data_lane_oe_n),
	.quad_enable_bit(quad_enable_bit),
	.xfer_mode(xfer_mode),
	.tx_take(tx_take),
	.rx(rx),
	.selected(selected),
	.paused(paused),
	.quad_refused(quad_refused),
	.hw_abort(hw_abort)
);

// *** verilog/sfpi_core.sv ***
// serial flash pin interface: framing, lane capture and launch, pause and pin reset
//
// Summary of operation
// (R1) select high floats every data lane
// (R2) select low: take instructions, return data
// (R3) ignore all until first select falling edge
// (R4) select rising never aborts internal cycles
// (R5) single lane: sample serial_in on rising clock
// (R6) single lane: change output on falling clock
// (R7) multi lane: sample rising, drive falling
// (R8) single and dual use lanes zero, one
// (R9) quad transfers need quad_enable_bit set
// (R10) quad enable turns pins into lanes two, three
// (R11) pause or reset on lane three not quad
// (R12) dedicated reset always honoured; high is inactive
// (R13) pause floats output, ignores clock and input
// (R14) reset low one microsecond returns power-on state
// (R15) bus modes zero and three, same edges
// (R16) select rising discards partial bits and counters
`timescale 1ns/1ps
module sfpi_core
	import sfpi_pkg::*;
#(
	parameter int RESET_MIN_CYCLES = sfpi_pkg::RESET_MIN_CYC,
	parameter bit LANE3_IS_RESET = 1'b0
) (
	input wire logic clk, // system clock, 125 MHz
	input wire logic reset, // synchronous, active high
	input wire logic pin_cs_n, // chip select pin, active low
	input wire logic pin_sclk, // serial clock pin from host
	input wire logic pin_hw_rst_n, // dedicated reset pin, active low
	input wire logic [sfpi_pkg::LANE_N-1:0] data_lane_in, // lane pin levels, bit 0 is serial_in
	output logic [sfpi_pkg::LANE_N-1:0] data_lane_out, // lane drive values
	output logic [sfpi_pkg::LANE_N-1:0] data_lane_oe_n, // lane enables, low drives
	input wire logic quad_enable_bit, // stored quad enable setting
	input wire sfpi_pkg::sfpi_mode_e xfer_mode, // lane count of current phase
	input wire logic xfer_dir_out, // high while device returns data
	input wire logic [sfpi_pkg::BYTE_W-1:0] tx_data, // next byte to send
	output logic tx_take, // pulse: tx_data consumed
	output sfpi_pkg::sfpi_rx_s rx, // received byte, pulse valid
	output logic selected, // frame in progress
	output logic paused, // pause held by lane three
	output logic quad_refused, // quad phase blocked this frame
	output logic hw_abort // pulse: abort internal cycle
);
	import sfpi_pkg::*;

	localparam int RCW = $clog2(RESET_MIN_CYCLES + 1);
	localparam logic [RCW-1:0] RST_LAST = RCW'(RESET_MIN_CYCLES - 1);
	localparam logic [RCW-1:0] RST_DONE = RCW'(RESET_MIN_CYCLES);

	if (RESET_MIN_CYCLES < 1)
	begin : g_chk
		$error("sfpi_core: RESET_MIN_CYCLES must be at least 1");
	end

	// ----------------------------------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------------------------------
	sfpi_pins_s pins_raw;
	sfpi_pins_s pins;
	logic sclk_q;
	logic cs_n_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;

	assign pins_raw = '{cs_n: pin_cs_n, hw_rst_n: pin_hw_rst_n, sclk: pin_sclk,
		lane: data_lane_in};

	sfpi_sync #(
		.WIDTH(PIN_W),
		.INIT(PIN_IDLE)
	) u_sync (
		.clk(clk),
		.reset(reset),
		.d(pins_raw),
		.q(pins)
	);

	// delayed copies for edges
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sclk_q <= 1'b0;
			cs_n_q <= 1'b1;
		end
		else
		begin
			sclk_q <= pins.sclk;
			cs_n_q <= pins.cs_n;
		end
	end

	// (R15) edges alone matter, idle level ignored
	assign sclk_rise = pins.sclk & ~sclk_q;
	assign sclk_fall = ~pins.sclk & sclk_q;
	assign cs_fall = ~pins.cs_n & cs_n_q;

	// ----------------------------------------------------------------
	// lane three role, pause and reset qualification
	// ----------------------------------------------------------------
	logic lane3_ctrl;
	logic hold_req;
	logic rst_low;
	logic rst_hold;
	logic [RCW-1:0] rst_cnt_q;

	// (R10) (R11) lane three is control only without quad
	assign lane3_ctrl = ~quad_enable_bit;
	assign hold_req = lane3_ctrl & ~LANE3_IS_RESET & ~pins.lane[3];
	// (R12) dedicated pin acts in every state
	assign rst_low = ~pins.hw_rst_n | (lane3_ctrl & LANE3_IS_RESET & ~pins.lane[3]);
	assign rst_hold = (rst_cnt_q == RST_DONE);

	// (R14) low time counted before acting
	always_ff @(posedge clk)
	begin
		if (reset || !rst_low)
			rst_cnt_q <= '0;
		else if (!rst_hold)
			rst_cnt_q <= rst_cnt_q + RCW'(1);
	end

	// (R14) one abort pulse when low time met
	always_ff @(posedge clk)
	begin
		if (reset)
			hw_abort <= 1'b0;
		else
			hw_abort <= rst_low && (rst_cnt_q == RST_LAST);
	end

	// ----------------------------------------------------------------
	// frame state
	// ----------------------------------------------------------------
	sfpi_state_e state_q;
	logic active;
	logic refused;
	logic shift_ok;

	// (R3) (R2) frame opens only on a select falling edge
	always_ff @(posedge clk)
	begin
		if (reset || rst_hold)
			state_q <= ST_WAIT;
		else
		begin
			unique case (state_q)
				ST_WAIT: if (cs_fall) state_q <= ST_ACTIVE;
				ST_ACTIVE:
				begin
					if (pins.cs_n)
						state_q <= ST_WAIT;
					else if (hold_req)
						state_q <= ST_PAUSED;
				end
				ST_PAUSED:
				begin
					if (pins.cs_n)
						state_q <= ST_WAIT;
					else if (!hold_req)
						state_q <= ST_ACTIVE;
				end
				default: state_q <= ST_WAIT;
			endcase
		end
	end

	assign active = (state_q == ST_ACTIVE);
	// (R9) quad phase refused without quad enable
	assign refused = (xfer_mode == SFPI_QUAD) && !quad_enable_bit;
	// (R13) no clock edge acts while paused
	assign shift_ok = active && !refused && !hold_req && !pins.cs_n;

	// status levels seen by the array logic
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			selected <= 1'b0;
			paused <= 1'b0;
			quad_refused <= 1'b0;
		end
		else
		begin
			selected <= (state_q != ST_WAIT) && !pins.cs_n && !rst_hold;
			paused <= (state_q == ST_PAUSED);
			if (active && refused && (sclk_rise || sclk_fall))
				quad_refused <= 1'b1;
			else if (state_q == ST_WAIT)
				quad_refused <= 1'b0;
		end
	end

	// (R4) deselect drives no abort, hw_abort comes from reset only

	// ----------------------------------------------------------------
	// receive path
	// ----------------------------------------------------------------
	logic [BYTE_W-1:0] rx_sh_q;
	logic [BYTE_W-1:0] rx_nxt;
	logic [CNT_W-1:0] rx_cnt_q;
	logic [CNT_W:0] rx_sum;
	logic [CNT_W:0] step;
	logic rx_first_q;

	// bits moved per clock edge
	always_comb
	begin
		unique case (xfer_mode)
			SFPI_DUAL: step = 4'h2;
			SFPI_QUAD: step = 4'h4;
			default: step = 4'h1;
		endcase
	end

	// (R5) (R7) (R8) lanes gathered msb first per mode
	always_comb
	begin
		unique case (xfer_mode)
			SFPI_DUAL: rx_nxt = {rx_sh_q[5:0], pins.lane[1:0]};
			SFPI_QUAD: rx_nxt = {rx_sh_q[3:0], pins.lane};
			default: rx_nxt = {rx_sh_q[6:0], pins.lane[0]};
		endcase
	end

	assign rx_sum = {1'b0, rx_cnt_q} + step;

	// (R5) capture on rising clock; (R16) cleared between frames
	always_ff @(posedge clk)
	begin
		if (reset || state_q == ST_WAIT)
		begin
			rx_sh_q <= '0;
			rx_cnt_q <= '0;
			rx_first_q <= 1'b1;
			rx <= '0;
		end
		else
		begin
			rx.valid <= 1'b0;
			if (shift_ok && sclk_rise && !xfer_dir_out)
			begin
				rx_sh_q <= rx_nxt;
				rx_cnt_q <= rx_sum[CNT_W-1:0];
				if (rx_sum[CNT_W])
				begin
					rx <= '{valid: 1'b1, first: rx_first_q, data: rx_nxt};
					rx_first_q <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit path
	// ----------------------------------------------------------------
	logic [BYTE_W-1:0] tx_sh_q;
	logic [BYTE_W-1:0] tx_word;
	logic [CNT_W-1:0] tx_cnt_q;
	logic [CNT_W:0] tx_sum;
	logic launch;
	logic float_all;

	assign tx_word = (tx_cnt_q == '0) ? tx_data : tx_sh_q;
	assign tx_sum = {1'b0, tx_cnt_q} + step;
	// (R6) (R7) launch only on falling clock
	assign launch = shift_ok && sclk_fall && xfer_dir_out;
	// (R1) (R13) float when deselected, paused or not sending
	assign float_all = !active || pins.cs_n || hold_req || rst_hold || !xfer_dir_out
		|| refused;

	// (R16) shifter and count cleared between frames
	always_ff @(posedge clk)
	begin
		if (reset || state_q == ST_WAIT)
		begin
			tx_sh_q <= '0;
			tx_cnt_q <= '0;
			tx_take <= 1'b0;
		end
		else
		begin
			tx_take <= launch && (tx_cnt_q == '0);
			if (launch)
			begin
				tx_sh_q <= BYTE_W'(tx_word << step);
				tx_cnt_q <= tx_sum[CNT_W-1:0];
			end
		end
	end

	// (R6) (R8) (R10) lane values and enables per mode
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			data_lane_out <= '0;
			data_lane_oe_n <= OE_ALL_OFF;
		end
		else if (float_all)
			data_lane_oe_n <= OE_ALL_OFF;
		else if (launch)
		begin
			unique case (xfer_mode)
				SFPI_DUAL:
				begin
					data_lane_out <= {2'b00, tx_word[7:6]};
					data_lane_oe_n <= OE_DUAL;
				end
				SFPI_QUAD:
				begin
					data_lane_out <= tx_word[7:4];
					data_lane_oe_n <= OE_QUAD;
				end
				default:
				begin
					data_lane_out <= {2'b00, tx_word[7], 1'b0};
					data_lane_oe_n <= OE_SINGLE;
				end
			endcase
		end
	end
endmodule

// *** verilog/sfpi_sync.sv ***
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module sfpi_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic [WIDTH-1:0] d, // asynchronous pin levels
	output logic [WIDTH-1:0] q // levels safe to use in clk domain
);
	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1)
	begin : g_chk
		$error("sfpi_sync: WIDTH must be at least 1");
	end

	// first stage feeds only the second stage
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_q <= INIT;
			q <= INIT;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
